// *** rtl/option_switches_pkg.sv ***
// Package of register map, field positions and reset values for the option switch block.
package option_switches_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] GROUP_ONE_OFFSET = 8'h00;
  localparam logic [7:0] GROUP_TWO_OFFSET = 8'h04;
  localparam logic [7:0] STATUS_OFFSET = 8'h08;
  localparam logic [7:0] MASK_OFFSET = 8'h0c;
  localparam logic [7:0] STATE_OFFSET = 8'h10;
  localparam logic [7:0] INDICATION_RESET_OFFSET = 8'h14;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int THRESHOLD_DOUBLING_POS = 4;
  localparam int EARTH_FAULT_INHIBIT_POS = 5;
  localparam int HIGH_OC_DISABLE_POS = 4;
  localparam int HIGH_EF_DISABLE_POS = 5;
  localparam int RECLOSE_ROUTING_POS = 6;
  localparam int EF_RECLOSE_SELECT_POS = 7;
  localparam int OPTION_CHANGE_POS = 4;

  // Stage indices for start, indication and status vectors.
  localparam int LOW_OC = 0;
  localparam int HIGH_OC = 1;
  localparam int LOW_EF = 2;
  localparam int HIGH_EF = 3;

  // ----------------------------------------------------------------
  // Widths, masks and reset values
  // ----------------------------------------------------------------
  localparam int STAGE_COUNT = 4;
  localparam int EVENT_COUNT = 5;
  localparam logic [7:0] GROUP_ONE_WRITE_MASK = 8'h3f;
  localparam logic [7:0] GROUP_ONE_RESET = 8'h00;
  localparam logic [7:0] GROUP_TWO_RESET = 8'h00;
  localparam logic [EVENT_COUNT-1:0] STATUS_RESET = 5'h00;
  localparam logic [EVENT_COUNT-1:0] MASK_RESET = 5'h00;

endpackage

// *** rtl/stage_if.sv ***
// Interface that carries stage starts and indicator control to the start indicator.
`timescale 1ns/100ps
interface stage_if;
  import option_switches_pkg::*;

  logic [STAGE_COUNT-1:0] start;
  logic [STAGE_COUNT-1:0] manual;
  logic [STAGE_COUNT-1:0] clear;
  logic [STAGE_COUNT-1:0] indication;

  modport ctrl (output start, output manual, output clear, input indication);
  modport ind (input start, input manual, input clear, output indication);
endinterface

// *** rtl/start_indicator.sv ***
// Start indicators of the four stages, each auto or hand reset.
`timescale 1ns/100ps
module start_indicator
  import option_switches_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  stage_if.ind stages
);

  typedef struct packed {
    logic [STAGE_COUNT-1:0] ind;
  } ind_state_t;

  ind_state_t s_q;
  ind_state_t s_d;

  // A start in the clearing cycle keeps the indication set.
  always_comb
  begin
    s_d = s_q;
    for (int i = 0; i < STAGE_COUNT; i++)
    begin
      if (stages.manual[i])
        s_d.ind[i] = (s_q.ind[i] & ~stages.clear[i]) | stages.start[i];
      else
        s_d.ind[i] = stages.start[i];
    end
  end

  always_ff @(posedge clock)
  begin
    if (reset)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign stages.indication = s_q.ind;

endmodule

// *** rtl/reclose_router.sv ***
// Steering of stage start signals to the auto-reclose outputs.
`timescale 1ns/100ps
module reclose_router
  import option_switches_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  input wire logic high_oc_start,
  input wire logic low_ef_start,
  input wire logic high_ef_start,
  input wire logic other_third_start,
  input wire logic routing,
  input wire logic ef_select,
  output logic first_reclose_output,
  output logic third_reclose_output
);

  typedef struct packed {
    logic first;
    logic third;
  } route_state_t;

  route_state_t s_q;
  route_state_t s_d;

  // The first reclose output is the same pin as the third start output.
  always_comb
  begin
    s_d = s_q;
    if (routing)
      s_d.first = high_oc_start;
    else
      s_d.first = other_third_start;
    if (ef_select)
      s_d.third = high_ef_start;
    else
      s_d.third = low_ef_start;
  end

  always_ff @(posedge clock)
  begin
    if (reset)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign first_reclose_output = s_q.first;
  assign third_reclose_output = s_q.third;

endmodule

// *** rtl/protection_stage_option_switches.sv ***
// Option switch registers and stage gating of the protection module.
//
// Operation
// - With threshold doubling set the high-set overcurrent threshold is doubled, else unchanged.
// - With earth-fault inhibit set the high-set earth-fault stage is held off while low-set overcurrent is started.
// - With earth-fault inhibit clear the high-set earth-fault stage runs whatever the phase stages do.
// - A stage whose reset option is 0 drops its start indication when its fault clears.
// - Group two bits 0 to 3 make the four stage start indications hold until an explicit reset.
// - High-set overcurrent disable blocks that stage fully and flags it out of service.
// - High-set earth-fault disable blocks that stage fully and flags it out of service.
// - Reclose routing set drives the shared first reclose output from the high-set overcurrent start.
// - Reclose routing clear keeps that start off the shared output, leaving it to other routing.
// - Earth-fault reclose select picks low-set (0) or high-set (1) earth-fault start for the third output.
`timescale 1ns/100ps
module protection_stage_option_switches
  import option_switches_pkg::*;
#(
  parameter int THRESHOLD_WIDTH = 16
)
(
  input wire logic CLOCK,
  input wire logic RESET,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [3:0] PSTRB,
  output logic PREADY,
  output logic [31:0] PRDATA,
  output logic PSLVERR,
  input wire logic [THRESHOLD_WIDTH-1:0] HIGH_OC_THRESHOLD,
  input wire logic LOW_OC_START,
  input wire logic HIGH_OC_START,
  input wire logic LOW_EF_START,
  input wire logic HIGH_EF_START,
  input wire logic OTHER_THIRD_START,
  output logic [THRESHOLD_WIDTH:0] HIGH_OC_THRESHOLD_EFF,
  output logic HIGH_OC_START_OUT,
  output logic HIGH_EF_START_OUT,
  output logic [1:0] OUT_OF_SERVICE,
  output logic [STAGE_COUNT-1:0] START_INDICATION,
  output logic FIRST_RECLOSE_OUTPUT,
  output logic THIRD_RECLOSE_OUTPUT,
  output logic IRQ
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] group_one;
    logic [7:0] group_two;
    logic [EVENT_COUNT-1:0] status;
    logic [EVENT_COUNT-1:0] mask;
    logic ack;
    logic [31:0] rdata;
    logic [THRESHOLD_WIDTH:0] threshold;
    logic [STAGE_COUNT-1:0] start;
    logic [STAGE_COUNT-1:0] start_prev;
    logic [STAGE_COUNT-1:0] clear;
    logic [1:0] oos;
    logic irq;
  } top_state_t;

  top_state_t s_q;
  top_state_t s_d;

  stage_if stages ();

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic is_mapped(input logic [7:0] addr);
    is_mapped = 1'b0;
    if (addr == GROUP_ONE_OFFSET)
      is_mapped = 1'b1;
    else if (addr == GROUP_TWO_OFFSET)
      is_mapped = 1'b1;
    else if (addr == STATUS_OFFSET)
      is_mapped = 1'b1;
    else if (addr == MASK_OFFSET)
      is_mapped = 1'b1;
    else if (addr == STATE_OFFSET)
      is_mapped = 1'b1;
    else if (addr == INDICATION_RESET_OFFSET)
      is_mapped = 1'b1;
  endfunction

  function automatic logic [31:0] read_word(input logic [7:0] addr, input top_state_t s,
                                            input logic [STAGE_COUNT-1:0] ind);
    read_word = 32'h0000_0000;
    if (addr == GROUP_ONE_OFFSET)
      read_word[7:0] = s.group_one;
    else if (addr == GROUP_TWO_OFFSET)
      read_word[7:0] = s.group_two;
    else if (addr == STATUS_OFFSET)
      read_word[EVENT_COUNT-1:0] = s.status;
    else if (addr == MASK_OFFSET)
      read_word[EVENT_COUNT-1:0] = s.mask;
    else if (addr == STATE_OFFSET)
      read_word[13:0] = {s.oos, s.start, ind, s.start_prev};
  endfunction

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  logic access;
  logic wr_now;
  logic lane0;
  logic hoc_disable;
  logic hef_disable;
  logic ef_inhibit;
  logic [EVENT_COUNT-1:0] events;
  logic [EVENT_COUNT-1:0] w1c;

  always_comb
  begin
    s_d = s_q;
    access = PSEL & PENABLE;
    wr_now = access & s_q.ack & PWRITE & is_mapped(PADDR);
    lane0 = PSTRB[0];
    hoc_disable = s_q.group_two[HIGH_OC_DISABLE_POS];
    hef_disable = s_q.group_two[HIGH_EF_DISABLE_POS];
    ef_inhibit = s_q.group_one[EARTH_FAULT_INHIBIT_POS];
    events = '0;
    w1c = '0;

    // One wait state: read data is captured, then pready is given.
    s_d.ack = access & ~s_q.ack;
    if (access & ~s_q.ack)
      s_d.rdata = read_word(PADDR, s_q, stages.indication);

    // Stage gating follows the stored options from the next cycle on.
    if (s_q.group_one[THRESHOLD_DOUBLING_POS])
      s_d.threshold = {HIGH_OC_THRESHOLD, 1'b0};
    else
      s_d.threshold = {1'b0, HIGH_OC_THRESHOLD};
    s_d.start[LOW_OC] = LOW_OC_START;
    s_d.start[HIGH_OC] = HIGH_OC_START & ~hoc_disable;
    s_d.start[LOW_EF] = LOW_EF_START;
    if (ef_inhibit)
      s_d.start[HIGH_EF] = HIGH_EF_START & ~hef_disable & ~LOW_OC_START;
    else
      s_d.start[HIGH_EF] = HIGH_EF_START & ~hef_disable;
    s_d.oos = {hef_disable, hoc_disable};
    s_d.start_prev = s_q.start;

    // Rising starts and option writes are the interrupt events.
    events[STAGE_COUNT-1:0] = s_q.start & ~s_q.start_prev;
    s_d.clear = '0;

    if (wr_now & lane0)
    begin
      if (PADDR == GROUP_ONE_OFFSET)
      begin
        s_d.group_one = PWDATA[7:0] & GROUP_ONE_WRITE_MASK;
        events[OPTION_CHANGE_POS] = 1'b1;
      end
      else if (PADDR == GROUP_TWO_OFFSET)
      begin
        s_d.group_two = PWDATA[7:0];
        events[OPTION_CHANGE_POS] = 1'b1;
      end
      else if (PADDR == STATUS_OFFSET)
        w1c = PWDATA[EVENT_COUNT-1:0];
      else if (PADDR == MASK_OFFSET)
        s_d.mask = PWDATA[EVENT_COUNT-1:0];
      else if (PADDR == INDICATION_RESET_OFFSET)
        s_d.clear = PWDATA[STAGE_COUNT-1:0];
    end

    // An event in the clearing cycle keeps its bit set.
    s_d.status = (s_q.status & ~w1c) | events;
    s_d.irq = |(s_d.status & s_d.mask);
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge CLOCK)
  begin
    if (RESET)
    begin
      s_q <= '0;
      s_q.group_one <= GROUP_ONE_RESET;
      s_q.group_two <= GROUP_TWO_RESET;
      s_q.status <= STATUS_RESET;
      s_q.mask <= MASK_RESET;
    end
    else
      s_q <= s_d;
  end

  // ----------------------------------------------------------------
  // Start indicators and reclose routing
  // ----------------------------------------------------------------
  assign stages.start = s_q.start;
  assign stages.manual = s_q.group_two[STAGE_COUNT-1:0];
  assign stages.clear = s_q.clear;

  start_indicator u_indicator (
    .clock(CLOCK),
    .reset(RESET),
    .stages(stages.ind)
  );

  reclose_router u_router (
    .clock(CLOCK),
    .reset(RESET),
    .high_oc_start(s_q.start[HIGH_OC]),
    .low_ef_start(s_q.start[LOW_EF]),
    .high_ef_start(s_q.start[HIGH_EF]),
    .other_third_start(OTHER_THIRD_START),
    .routing(s_q.group_two[RECLOSE_ROUTING_POS]),
    .ef_select(s_q.group_two[EF_RECLOSE_SELECT_POS]),
    .first_reclose_output(FIRST_RECLOSE_OUTPUT),
    .third_reclose_output(THIRD_RECLOSE_OUTPUT)
  );

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign PREADY = s_q.ack;
  assign PRDATA = s_q.rdata;
  assign PSLVERR = s_q.ack & PSEL & PENABLE & ~is_mapped(PADDR);
  assign HIGH_OC_THRESHOLD_EFF = s_q.threshold;
  assign HIGH_OC_START_OUT = s_q.start[HIGH_OC];
  assign HIGH_EF_START_OUT = s_q.start[HIGH_EF];
  assign OUT_OF_SERVICE = s_q.oos;
  assign START_INDICATION = stages.indication;
  assign IRQ = s_q.irq;

endmodule

// *** verif/stage_model.sv ***
// Model of the stage comparators and routing that feed the option switch block.
`timescale 1ns/100ps
module stage_model (
  input wire logic clock,
  input wire logic [4:0] want,
  input wire logic routed,
  output logic [3:0] starts,
  output logic other
);
  // Starts change on the clock edge, and the other signal of the shared
  // output stays low while the high-set start is routed there.
  always_ff @(posedge clock)
  begin
    starts <= want[3:0];
    other <= want[4] & ~routed;
  end
endmodule

// *** verif/option_chk.sv ***
// Assertions on the ports of the option switch block.
`timescale 1ns/100ps
module option_chk
  import option_switches_pkg::*;
#(
  parameter int THRESHOLD_WIDTH = 16
)
(
  input wire logic CLOCK,
  input wire logic RESET,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [3:0] PSTRB,
  input wire logic PREADY,
  input wire logic [THRESHOLD_WIDTH-1:0] HIGH_OC_THRESHOLD,
  input wire logic LOW_OC_START,
  input wire logic HIGH_OC_START,
  input wire logic LOW_EF_START,
  input wire logic HIGH_EF_START,
  input wire logic OTHER_THIRD_START,
  input wire logic [THRESHOLD_WIDTH:0] HIGH_OC_THRESHOLD_EFF,
  input wire logic HIGH_OC_START_OUT,
  input wire logic HIGH_EF_START_OUT,
  input wire logic [1:0] OUT_OF_SERVICE,
  input wire logic [STAGE_COUNT-1:0] START_INDICATION,
  input wire logic FIRST_RECLOSE_OUTPUT,
  input wire logic THIRD_RECLOSE_OUTPUT
);
  // ------
  // Shadow copies of the option groups, updated by bus writes.
  // ------
  logic [7:0] g1_q;
  logic [7:0] g2_q;
  wire logic wr = PSEL && PENABLE && PREADY && PWRITE;
  wire logic first_src = g2_q[6] ? HIGH_OC_START_OUT : OTHER_THIRD_START;
  wire logic third_src = g2_q[7] ? HIGH_EF_START_OUT : LOW_EF_START;
  always_ff @(posedge CLOCK)
  begin
    if (RESET)
    begin
      g1_q <= GROUP_ONE_RESET;
      g2_q <= GROUP_TWO_RESET;
    end
    else if (wr && PSTRB[0])
    begin
      if (PADDR == GROUP_ONE_OFFSET)
        g1_q <= PWDATA[7:0] & GROUP_ONE_WRITE_MASK;
      if (PADDR == GROUP_TWO_OFFSET)
        g2_q <= PWDATA[7:0];
    end
  end
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (RESET);
  property p_dbl;
    !$past(RESET) |-> HIGH_OC_THRESHOLD_EFF ==
      ($past(g1_q[4]) ? {$past(HIGH_OC_THRESHOLD), 1'b0} : {1'b0, $past(HIGH_OC_THRESHOLD)});
  endproperty
  property p_hoc;
    !$past(RESET) |-> HIGH_OC_START_OUT == $past(HIGH_OC_START && !g2_q[4]);
  endproperty
  property p_hef;
    !$past(RESET) |-> HIGH_EF_START_OUT ==
      $past(HIGH_EF_START && !g2_q[5] && !(g1_q[5] && LOW_OC_START));
  endproperty
  property p_oos;
    !$past(RESET) |-> OUT_OF_SERVICE == $past(g2_q[5:4]);
  endproperty
  property p_first;
    $stable({g2_q, first_src}) [*3] |-> FIRST_RECLOSE_OUTPUT == first_src;
  endproperty
  property p_third;
    $stable({g2_q, third_src}) [*3] |-> THIRD_RECLOSE_OUTPUT == third_src;
  endproperty
  property p_auto;
    (!g2_q[0] && $stable({g2_q, LOW_OC_START})) [*3] |-> START_INDICATION[0] == LOW_OC_START;
  endproperty
  property p_hold;
    g2_q[1] && START_INDICATION[1] && !wr && !$past(wr) && !$past(wr, 2) |=> START_INDICATION[1];
  endproperty
  property p_rdy;
    PSEL && !PENABLE |=> !PREADY ##1 PREADY;
  endproperty
  a_dbl: assert property (p_dbl) else $error("threshold wrong");
  a_hoc: assert property (p_hoc) else $error("high oc start wrong");
  a_hef: assert property (p_hef) else $error("high ef start wrong");
  a_oos: assert property (p_oos) else $error("out of service wrong");
  a_first: assert property (p_first) else $error("first reclose wrong");
  a_third: assert property (p_third) else $error("third reclose wrong");
  a_auto: assert property (p_auto) else $error("auto indication wrong");
  a_hold: assert property (p_hold) else $error("held indication lost");
  a_rdy: assert property (p_rdy) else $error("ready late");
  c_clr: cover property (wr && PADDR == INDICATION_RESET_OFFSET);
  c_dbl: cover property (HIGH_OC_THRESHOLD_EFF[THRESHOLD_WIDTH]);
  c_first: cover property ($rose(FIRST_RECLOSE_OUTPUT));
endmodule
bind protection_stage_option_switches option_chk #(.THRESHOLD_WIDTH(THRESHOLD_WIDTH)) u_chk (.*);

// *** verif/tb_protection_stage_option_switches.sv ***
// Self-checking bench of the option switch block.
`timescale 1ns/100ps
`define CHK(n, e, g) check(n, (e) === (g), 32'(e), 32'(g));
module tb_protection_stage_option_switches
  import option_switches_pkg::*;
  ;
  typedef struct packed {
    logic [7:0] g1;
    logic [7:0] g2;
    logic [4:0] st;
    logic [16:0] eff;
    logic [1:0] gs;
    logic [1:0] oos;
    logic [1:0] ro;
  } row_t;
  localparam row_t ROWS [9] = '{
    '{8'h00, 8'h00, 5'h0f, 17'h08001, 2'h3, 2'h0, 2'h1},
    '{8'h10, 8'h00, 5'h10, 17'h10002, 2'h0, 2'h0, 2'h2},
    '{8'h20, 8'h00, 5'h09, 17'h08001, 2'h0, 2'h0, 2'h0},
    '{8'h20, 8'h00, 5'h08, 17'h08001, 2'h1, 2'h0, 2'h0},
    '{8'h00, 8'h10, 5'h02, 17'h08001, 2'h0, 2'h1, 2'h0},
    '{8'h00, 8'h20, 5'h08, 17'h08001, 2'h0, 2'h2, 2'h0},
    '{8'h00, 8'h40, 5'h12, 17'h08001, 2'h2, 2'h0, 2'h2},
    '{8'h00, 8'h80, 5'h04, 17'h08001, 2'h0, 2'h0, 2'h0},
    '{8'h00, 8'h80, 5'h08, 17'h08001, 2'h1, 2'h0, 2'h1}
  };
  logic CLOCK = 1'b0;
  logic RESET = 1'b1;
  logic PSEL = 1'b0;
  logic PENABLE = 1'b0;
  logic PWRITE = 1'b0;
  logic [7:0] PADDR = 8'h00;
  logic [31:0] PWDATA = 32'h0;
  logic [3:0] PSTRB = 4'h0;
  logic [15:0] HIGH_OC_THRESHOLD = 16'h8001;
  logic [4:0] want = 5'h00;
  logic routed = 1'b0;
  logic PREADY, PSLVERR, IRQ, err, HIGH_OC_START_OUT, HIGH_EF_START_OUT;
  logic FIRST_RECLOSE_OUTPUT, THIRD_RECLOSE_OUTPUT;
  logic [31:0] PRDATA, rd;
  logic [16:0] HIGH_OC_THRESHOLD_EFF;
  logic [1:0] OUT_OF_SERVICE;
  logic [3:0] START_INDICATION;
  wire logic LOW_OC_START, HIGH_OC_START, LOW_EF_START, HIGH_EF_START, OTHER_THIRD_START;
  int err_total = 0;
  int comparisons = 0;
  int cyc = 0;
  protection_stage_option_switches u_dut (.*);
  stage_model u_model (.clock(CLOCK), .want(want), .routed(routed), .other(OTHER_THIRD_START),
    .starts({HIGH_EF_START, LOW_EF_START, HIGH_OC_START, LOW_OC_START}));
  always #2 CLOCK = ~CLOCK;
  task automatic give_verdict;
    if (err_total == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge CLOCK)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      err_total++;
      give_verdict;
    end
  end
  task automatic check(input string n, input bit ok, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (!ok)
    begin
      $display("MISMATCH %s expected %h seen %h", n, e, g);
      err_total++;
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge CLOCK);
  endtask
  // ------
  // One bus transfer: the request stands until ready is seen.
  // ------
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge CLOCK);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    PSTRB <= s;
    @(posedge CLOCK);
    PENABLE <= 1'b1;
    @(posedge CLOCK);
    while (PREADY !== 1'b1)
      @(posedge CLOCK);
    rd = PRDATA;
    err = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask
  initial
  begin
    row_t r;
    repeat (20) @(posedge CLOCK);
    `CHK("reset outputs", 32'h0, {IRQ, START_INDICATION, HIGH_OC_THRESHOLD_EFF})
    RESET <= 1'b0;
    for (int a = 0; a <= 20; a += 4)
    begin
      apb(1'b0, 8'(a), 32'h0, 4'h0);
      `CHK("reset value", 32'h0, rd)
    end
    foreach (ROWS[i])
    begin
      r = ROWS[i];
      routed <= r.g2[6];
      apb(1'b1, GROUP_ONE_OFFSET, {24'h0, r.g1}, 4'h1);
      apb(1'b1, GROUP_TWO_OFFSET, {24'h0, r.g2}, 4'h1);
      want <= r.st;
      tick(5);
      `CHK("threshold", r.eff, HIGH_OC_THRESHOLD_EFF)
      `CHK("gated", r.gs, {HIGH_OC_START_OUT, HIGH_EF_START_OUT})
      `CHK("oos", r.oos, OUT_OF_SERVICE)
      `CHK("reclose", r.ro, {FIRST_RECLOSE_OUTPUT, THIRD_RECLOSE_OUTPUT})
      `CHK("indication", {r.gs[0], r.st[2], r.gs[1], r.st[0]}, START_INDICATION)
    end
    want <= 5'h00;
    routed <= 1'b0;
    apb(1'b1, GROUP_TWO_OFFSET, 32'h2, 4'h1);
    apb(1'b1, MASK_OFFSET, 32'h2, 4'h1);
    apb(1'b1, STATUS_OFFSET, 32'h1f, 4'h1);
    want <= 5'h03;
    tick(3);
    want <= 5'h00;
    tick(5);
    `CHK("held", 2'h2, START_INDICATION[1:0])
    `CHK("irq", 1'b1, IRQ)
    apb(1'b0, STATUS_OFFSET, 32'h0, 4'h0);
    `CHK("status", 32'h3, rd)
    apb(1'b1, STATUS_OFFSET, 32'h2, 4'h1);
    tick(2);
    `CHK("irq masked", 1'b0, IRQ)
    apb(1'b1, INDICATION_RESET_OFFSET, 32'h2, 4'h1);
    tick(3);
    `CHK("released", 4'h0, START_INDICATION)
    apb(1'b1, GROUP_ONE_OFFSET, 32'hff, 4'h1);
    apb(1'b1, GROUP_ONE_OFFSET, 32'h0, 4'h0);
    apb(1'b0, GROUP_ONE_OFFSET, 32'h0, 4'h0);
    `CHK("group one", 32'h3f, rd)
    apb(1'b0, 8'h20, 32'h0, 4'h0);
    `CHK("unmapped", 1'b1, err)
    give_verdict;
  end
endmodule
